/* rtl/fso_top.sv */
// flash security and option logic with an axi4-lite register slave
// Contract
// [RL1] reset copies option byte into working register
// [RL2] software reprograms option byte then resets
// [RL3] key enable zero refuses backdoor unlock
// [RL4] key writes only from secured firmware
// [RL5] matching eight-byte key unsecures until reset
// [RL6] redirect disable bit one disables redirection
// [RL7] secure state blocks unsecured memory accesses
// [RL8] key or blank check sets unsecure code
// [RL9] code one-zero means unsecured
// [RL10] other codes secure; bits five:two read zero
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
module fso_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    input  wire logic [7:0]        nonvolatile_option_byte_in,
    input  wire logic [63:0]       stored_backdoor_key_in,
    input  wire logic              firmware_secure_in,
    input  wire logic              background_debug_mode_in,
    input  wire logic              mem_req_in,
    input  wire logic              mem_src_unsecured_in,
    output logic                   mem_grant_out,
    output logic                   mem_block_out,
    output logic                   redirect_enable_out,
    output logic                   secure_out,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    initial begin
        if (ADDR_W < 8) $error("fso_top: ADDR_W must be at least 8");
    end

    // =====================================================
    // decode helpers
    function automatic logic is_secure(input logic [7:0] opt);
        is_secure = opt[fso_pkg::SEC_LSB +: 2] != fso_pkg::SEC_UNSECURE;
    endfunction

    // =====================================================
    // option, key and bus state
    logic [7:0]        option;
    logic [7:0]        next_option;
    logic              loaded;
    logic              next_loaded;
    logic [63:0]       key_buf;
    logic [63:0]       next_key_buf;
    logic              key_fail;
    logic              next_key_fail;
    logic              aw_held;
    logic              next_aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [ADDR_W-1:0] next_aw_addr;
    logic              w_held;
    logic              next_w_held;
    logic [31:0]       w_data;
    logic [31:0]       next_w_data;
    logic [3:0]        w_strb;
    logic [3:0]        next_w_strb;
    logic              bvalid;
    logic              next_bvalid;
    logic [1:0]        bresp;
    logic [1:0]        next_bresp;
    logic              rvalid;
    logic              next_rvalid;
    logic [31:0]       rdata;
    logic [31:0]       next_rdata;
    logic [1:0]        rresp;
    logic [1:0]        next_rresp;
    logic              grant;
    logic              next_grant;
    logic              block;
    logic              next_block;
    logic              key_writer_ok;
    logic              do_write;
    logic              do_read;
    logic [31:0]       wmask;

    // key bytes only from secured user firmware, never debug
    assign key_writer_ok = firmware_secure_in
                         && !background_debug_mode_in; // [RL4]
    assign do_write = (aw_held || s_axi_awvalid)
                   && (w_held || s_axi_wvalid) && !bvalid;
    assign do_read  = s_axi_arvalid && !rvalid;

    always_comb begin
        logic [ADDR_W-1:0] wa;
        logic [31:0]       wd;
        logic [3:0]        ws;
        logic [7:0]        ra;
        wa = aw_held ? aw_addr : s_axi_awaddr;
        wd = w_held ? w_data : s_axi_wdata;
        ws = w_held ? w_strb : s_axi_wstrb;
        ra = s_axi_araddr[7:0];
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{ws[i]}};
        end
        next_option   = option;
        next_loaded   = 1'b1;
        next_key_buf  = key_buf;
        next_key_fail = key_fail;
        next_aw_held  = aw_held;
        next_aw_addr  = aw_addr;
        next_w_held   = w_held;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rdata    = rdata;
        next_rresp    = rresp;
        if (!loaded) begin
            // first cycle after reset release loads the option byte
            next_option = nonvolatile_option_byte_in
                        & fso_pkg::OPTION_MASK; // [RL1] [RL10]
        end
        if (s_axi_awvalid && !aw_held && !bvalid && !do_write) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held && !bvalid && !do_write) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = fso_pkg::RESP_OKAY;
            case (wa[7:0])
                fso_pkg::ADDR_KEY_LO: begin
                    if (key_writer_ok) begin // [RL4]
                        next_key_buf[31:0] = (key_buf[31:0] & ~wmask)
                                           | (wd & wmask);
                    end else begin
                        next_bresp = fso_pkg::RESP_SLVERR;
                    end
                end
                fso_pkg::ADDR_KEY_HI: begin
                    if (key_writer_ok) begin // [RL4]
                        next_key_buf[63:32] = (key_buf[63:32] & ~wmask)
                                            | (wd & wmask);
                    end else begin
                        next_bresp = fso_pkg::RESP_SLVERR;
                    end
                end
                fso_pkg::ADDR_CTRL: begin
                    if (ws[0] && wd[fso_pkg::CTRL_KEY_GO_BIT]) begin
                        if (key_writer_ok
                            && option[fso_pkg::KEY_EN_BIT] // [RL3]
                            && key_buf == stored_backdoor_key_in) begin
                            next_option[fso_pkg::SEC_LSB +: 2] =
                                fso_pkg::SEC_UNSECURE; // [RL5] [RL8]
                        end else begin
                            next_key_fail = 1'b1; // [RL3]
                        end
                    end
                    if (ws[0] && wd[fso_pkg::CTRL_BLANK_OK_BIT]) begin
                        next_option[fso_pkg::SEC_LSB +: 2] =
                            fso_pkg::SEC_UNSECURE; // [RL8]
                    end
                end
                fso_pkg::ADDR_OPTION,
                fso_pkg::ADDR_STATUS: begin
                    next_bresp = fso_pkg::RESP_SLVERR;
                end
                default: begin
                    next_bresp = fso_pkg::RESP_DECERR;
                end
            endcase
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp  = fso_pkg::RESP_OKAY;
            case (ra)
                fso_pkg::ADDR_OPTION: begin
                    next_rdata = {24'h000000, option}; // [RL10]
                end
                fso_pkg::ADDR_KEY_LO,
                fso_pkg::ADDR_KEY_HI,
                fso_pkg::ADDR_CTRL: begin
                    next_rdata = 32'h00000000;
                end
                fso_pkg::ADDR_STATUS: begin
                    next_rdata = 32'h00000000;
                    next_rdata[fso_pkg::STAT_SECURE_BIT] =
                        is_secure(option); // [RL9]
                    next_rdata[fso_pkg::STAT_REDIR_BIT] =
                        !option[fso_pkg::REDIR_DIS_BIT];
                    next_rdata[fso_pkg::STAT_KEYFAIL_BIT] = key_fail;
                    next_rdata[fso_pkg::STAT_LOADED_BIT]  = loaded;
                end
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = fso_pkg::RESP_DECERR;
                end
            endcase
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // secure state blocks unsecured sources and debug access
        next_grant = 1'b0;
        next_block = 1'b0;
        if (mem_req_in) begin
            if (is_secure(option) && (mem_src_unsecured_in
                || background_debug_mode_in)) begin // [RL7] [RL10]
                next_block = 1'b1;
            end else begin
                next_grant = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            option   <= fso_pkg::OPTION_RESET;
            loaded   <= 1'b0;
            key_buf  <= 64'h0000000000000000;
            key_fail <= 1'b0;
            aw_held  <= 1'b0;
            aw_addr  <= '0;
            w_held   <= 1'b0;
            w_data   <= 32'h00000000;
            w_strb   <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            rvalid   <= 1'b0;
            rdata    <= 32'h00000000;
            rresp    <= 2'h0;
            grant    <= 1'b0;
            block    <= 1'b0;
        end else begin
            option   <= next_option;
            loaded   <= next_loaded;
            key_buf  <= next_key_buf;
            key_fail <= next_key_fail;
            aw_held  <= next_aw_held;
            aw_addr  <= next_aw_addr;
            w_held   <= next_w_held;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
            grant    <= next_grant;
            block    <= next_block;
        end
    end

    // =====================================================
    // outputs, all from flip-flops
    logic redir_q;
    logic secure_q;
    logic awready_q;
    logic wready_q;
    logic arready_q;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            redir_q   <= 1'b0;
            secure_q  <= 1'b1;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            arready_q <= 1'b1;
        end else begin
            redir_q   <= loaded && !option[fso_pkg::REDIR_DIS_BIT]; // [RL6]
            secure_q  <= !loaded || is_secure(next_option); // [RL9]
            awready_q <= !next_aw_held && !next_bvalid;
            wready_q  <= !next_w_held && !next_bvalid;
            arready_q <= !next_rvalid;
        end
    end

    assign redirect_enable_out = redir_q;
    assign secure_out          = secure_q;
    assign mem_grant_out       = grant;
    assign mem_block_out       = block;
    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = wready_q;
    assign s_axi_bvalid        = bvalid;
    assign s_axi_bresp         = bresp;
    assign s_axi_arready       = arready_q;
    assign s_axi_rvalid        = rvalid;
    assign s_axi_rdata         = rdata;
    assign s_axi_rresp         = rresp;
endmodule
`default_nettype wire

/* rtl/fso_pkg.sv */
// package of constants for the flash security and option block
`default_nettype none
package fso_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] ADDR_OPTION  = 8'h00;
    localparam logic [7:0] ADDR_KEY_LO  = 8'h04;
    localparam logic [7:0] ADDR_KEY_HI  = 8'h08;
    localparam logic [7:0] ADDR_CTRL    = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h10;
    // =====================================================
    // option fields
    localparam int          KEY_EN_BIT   = 7;
    localparam int          REDIR_DIS_BIT = 6;
    localparam int          SEC_LSB      = 0;
    localparam logic [1:0]  SEC_UNSECURE = 2'h2;
    localparam logic [7:0]  OPTION_MASK  = 8'hc3;
    localparam logic [7:0]  OPTION_RESET = 8'h00;
    // =====================================================
    // control and status fields
    localparam int          CTRL_KEY_GO_BIT   = 0;
    localparam int          CTRL_BLANK_OK_BIT = 1;
    localparam int          STAT_SECURE_BIT   = 0;
    localparam int          STAT_REDIR_BIT    = 1;
    localparam int          STAT_KEYFAIL_BIT  = 2;
    localparam int          STAT_LOADED_BIT   = 3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

/* bench/fso_properties.sv */
// assertion checker for the flash security and option block
`default_nettype none
module fso_properties #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_in,
    input wire logic              arst_n_in,
    input wire logic              background_debug_mode_in,
    input wire logic              mem_req_in,
    input wire logic              mem_src_unsecured_in,
    input wire logic              mem_grant_out,
    input wire logic              mem_block_out,
    input wire logic              secure_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // =====================================================
    // sequences
    sequence s_unsec_req;
        mem_req_in && mem_src_unsecured_in && secure_out ##1 secure_out;
    endsequence
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_key_dbg;
        s_wr ##0 (background_debug_mode_in
            && (s_axi_awaddr == fso_pkg::ADDR_KEY_LO
            || s_axi_awaddr == fso_pkg::ADDR_KEY_HI));
    endsequence
    // =====================================================
    // properties
    property p_block;
        s_unsec_req |-> mem_block_out && !mem_grant_out;
    endproperty
    property p_open;
        mem_req_in && !secure_out |=> mem_grant_out;
    endproperty
    property p_trusted;
        mem_req_in && !mem_src_unsecured_in && !background_debug_mode_in
            |=> mem_grant_out && !mem_block_out;
    endproperty
    property p_idle;
        !mem_req_in |=> !mem_grant_out && !mem_block_out;
    endproperty
    property p_sticky;
        !secure_out |=> !secure_out;
    endproperty
    property p_key_dbg;
        s_key_dbg |=> s_axi_bvalid && s_axi_bresp == fso_pkg::RESP_SLVERR;
    endproperty
    property p_opt_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == fso_pkg::ADDR_OPTION
            |=> s_axi_rvalid && s_axi_rdata[5:2] == 4'h0;
    endproperty
    property p_wresp;
        s_wr |=> s_axi_bvalid;
    endproperty
    a_block: assert property (p_block)
        else $error("unsecured access not blocked");
    a_open: assert property (p_open)
        else $error("access refused while unsecured");
    a_trusted: assert property (p_trusted)
        else $error("secured source not granted");
    a_idle: assert property (p_idle)
        else $error("grant or block without request");
    a_sticky: assert property (p_sticky)
        else $error("security reengaged before reset");
    a_key_dbg: assert property (p_key_dbg)
        else $error("debug key write accepted");
    a_opt_rd: assert property (p_opt_rd)
        else $error("unused option bits not zero");
    a_wresp: assert property (p_wresp)
        else $error("write response missing");
endmodule
bind fso_top fso_properties #(.ADDR_W(ADDR_W)) i_chk (.*);
`default_nettype wire

/* bench/fso_nv_model.sv */
// nonvolatile option byte and backdoor key storage model
`default_nettype none
module fso_nv_model #(
    parameter logic [63:0] KEY = 64'h0123456789abcdef
) (
    input  wire logic        clk_in,
    input  wire logic        prog_in,
    input  wire logic [7:0]  prog_val_in,
    output var logic  [7:0]  nonvolatile_option_byte_out,
    output logic      [63:0] stored_backdoor_key_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] nv_byte = 8'h00;
    assign stored_backdoor_key_out = KEY;
    assign nonvolatile_option_byte_out = nv_byte;
    // reprogramming only shows after the next reset
    always @(posedge clk_in) begin
        if (prog_in) nv_byte <= prog_val_in;
    end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// register level testbench for the flash security and option block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] KEY = 64'h0123456789abcdef;
    logic clk_in, arst_n_in, prog, firmware_secure_in;
    logic background_debug_mode_in, mem_req_in, mem_src_unsecured_in;
    logic mem_grant_out, mem_block_out, redirect_enable_out, secure_out;
    logic [7:0]  prog_val, nonvolatile_option_byte_in;
    logic [63:0] stored_backdoor_key_in;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int   num_errors, n_tests;
    fso_nv_model #(.KEY(KEY)) i_nv (.clk_in, .prog_in(prog),
        .prog_val_in(prog_val),
        .nonvolatile_option_byte_out(nonvolatile_option_byte_in),
        .stored_backdoor_key_out(stored_backdoor_key_in));
    fso_top i_dut (.*);
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // =====================================================
    // tasks
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h0, g}, {31'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk_word({30'h0, s_axi_bresp}, {30'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_word(s_axi_rdata, d);
        chk_word({30'h0, s_axi_rresp}, {30'h0, e});
    endtask
    task automatic mem(input logic u, input logic b, input logic g);
        @(posedge clk_in);
        mem_req_in <= 1'b1;
        mem_src_unsecured_in <= u;
        background_debug_mode_in <= b;
        @(posedge clk_in);
        mem_req_in <= 1'b0;
        background_debug_mode_in <= 1'b0;
        #1 chk_bit(mem_grant_out, g);
        chk_bit(mem_block_out, ~g);
    endtask
    task automatic boot(input logic [7:0] v);
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        prog <= 1'b1;
        prog_val <= v;
        @(posedge clk_in);
        prog <= 1'b0;
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic key(input logic [63:0] k, input logic [1:0] e);
        wr(fso_pkg::ADDR_KEY_LO, k[31:0], e);
        wr(fso_pkg::ADDR_KEY_HI, k[63:32], e);
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // =====================================================
    // tests
    initial begin
        {arst_n_in, prog, prog_val, mem_req_in, mem_src_unsecured_in} = '0;
        {background_debug_mode_in, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        firmware_secure_in = 1'b1;
        boot(8'hff);
        chk_bit(secure_out, 1'b1);
        chk_bit(redirect_enable_out, 1'b0);
        rd(fso_pkg::ADDR_OPTION, 32'hc3, fso_pkg::RESP_OKAY);
        mem(1'b1, 1'b0, 1'b0);
        mem(1'b0, 1'b1, 1'b0);
        mem(1'b0, 1'b0, 1'b1);
        background_debug_mode_in <= 1'b1;
        key(KEY, fso_pkg::RESP_SLVERR);
        background_debug_mode_in <= 1'b0;
        firmware_secure_in <= 1'b0;
        key(KEY, fso_pkg::RESP_SLVERR);
        firmware_secure_in <= 1'b1;
        wr(fso_pkg::ADDR_CTRL, 32'h1, fso_pkg::RESP_OKAY);
        key(~KEY, fso_pkg::RESP_OKAY);
        wr(fso_pkg::ADDR_CTRL, 32'h1, fso_pkg::RESP_OKAY);
        rd(fso_pkg::ADDR_STATUS, 32'hd, fso_pkg::RESP_OKAY);
        key(KEY, fso_pkg::RESP_OKAY);
        wr(fso_pkg::ADDR_CTRL, 32'h1, fso_pkg::RESP_OKAY);
        rd(fso_pkg::ADDR_STATUS, 32'hc, fso_pkg::RESP_OKAY);
        rd(fso_pkg::ADDR_OPTION, 32'hc2, fso_pkg::RESP_OKAY);
        mem(1'b1, 1'b0, 1'b1);
        wr(fso_pkg::ADDR_OPTION, 32'h0, fso_pkg::RESP_SLVERR);
        rd(8'h20, 32'h0, fso_pkg::RESP_DECERR);
        boot(8'h81);
        chk_bit(redirect_enable_out, 1'b1);
        // a write with no byte strobes must leave the key untouched
        key(KEY, fso_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'h0;
        wr(fso_pkg::ADDR_KEY_LO, 32'h0, fso_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        wr(fso_pkg::ADDR_CTRL, 32'h1, fso_pkg::RESP_OKAY);
        rd(fso_pkg::ADDR_STATUS, 32'ha, fso_pkg::RESP_OKAY);
        boot(8'h01);
        key(KEY, fso_pkg::RESP_OKAY);
        wr(fso_pkg::ADDR_CTRL, 32'h1, fso_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_in);
        #1 chk_bit(secure_out, 1'b1);
        wr(fso_pkg::ADDR_CTRL, 32'h2, fso_pkg::RESP_OKAY);
        repeat (2) @(posedge clk_in);
        #1 chk_bit(secure_out, 1'b0);
        for (int c = 0; c < 4; c++) begin
            boot(8'(c));
            chk_bit(secure_out, c != 2);
        end
        end_of_test();
    end
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
